// ===== src/cs_core_state.sv
`timescale 1ns/1ps
`include "cs_defines.svh"

// Overview of operation
// [RL1] lowest region holds code and data; vector table starts at address zero
// [RL2] data memory 0x20000000-0x3FFFFFFF, instruction fetch allowed there
// [RL3] peripherals at 0x40000000-0x5FFFFFFF; executing from there faults
// [RL4] core-internal registers live at 0xE0000000-0xE00FFFFF
// [RL5] after reset, word at address 0 loads the main stack pointer
// [RL6] after reset, word at address 4 loads counter; bit 0 sets state bit
// [RL7] thread mode uses process stack when stack select bit 1 is set
// [RL8] two banked stack pointers share register 13; only one visible
// [RL9] mask bit blocks configurable-priority exceptions; mask resets to zero
// [RL10] read-only field shows number of serviced exception, zero after reset
// [RL11] condition flags kept in a readable, writable status part
// [RL12] registers 0-7 reach all ops; 8-12 reachable by a subset only
// [RL13] sixteen 32-bit registers, 32-bit data path and memory interface
// [RL14] 32 by 32 multiply gives 32-bit result in one cycle
// [RL15] instructions pass through exactly two pipeline stages
// [RL16] return information saved in register 14 on calls and exception entry
// [RL17] writing register 15 redirects program flow to the written address
// [RL18] handler mode always uses main stack; stack select writes ignored
// [RL19] unmaskable exceptions ignore the mask bit
// [RL20] executing with the state bit clear raises a hard fault
// [RL21] access to an unused address region is a bus error
module cs_core_state
  import cs_pkg::*;
(
  input  logic        ref_clk,
  input  logic        nrst,
  input  logic        op_valid,
  input  cs_op_s      op,
  output logic        op_ready,
  output logic        flush,
  output logic        bus_req,
  output logic        bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input  logic [31:0] bus_rdata,
  input  logic        bus_ready,
  input  logic        bus_err,
  input  logic        exc_req,
  input  logic [5:0]  exc_num,
  input  logic        exc_cfg,
  output logic        exc_ack,
  output logic        hard_fault,
  output logic [31:0] counter_out,
  output cs_status_s  status_out,
  output logic        mask_out,
  output logic        spsel_out
);

  logic              rst_n_q1;
  logic              rst_n;
  cs_state_e         state_reg;
  logic [12:0][31:0] gpr_reg;
  logic [31:0]       main_sp_reg;
  logic [31:0]       proc_sp_reg;
  logic [31:0]       link_reg;
  logic [31:0]       prog_cnt_reg;
  logic [3:0]        flag_reg;
  logic              tbit_reg;
  logic              mask_reg;
  logic              spsel_reg;
  logic [5:0]        exc_num_reg;
  cs_op_s            s1_reg;
  logic              s1_valid_reg;
  logic              ready_reg;
  logic              flush_reg;
  logic              ack_reg;
  logic              fault_reg;
  logic              req_reg;
  logic              write_reg;
  logic [31:0]       addr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        ld_rd_reg;

  logic              handler;
  logic              use_proc_sp;
  logic              exec_go;
  logic              exec_ok;
  logic              fault_now;
  logic              mem_fault;
  logic              take_int;
  logic              enter_exc;
  logic              is_mem;
  logic              ld_done;
  logic              redirect;
  logic              f_exec_ok;
  logic              d_mapped;
  logic              set_flags;
  logic              branch;
  logic              wr_en;
  logic [3:0]        wr_idx;
  logic [31:0]       wr_data;
  logic [31:0]       cur_sp;
  logic [31:0]       a_val;
  logic [31:0]       b_val;
  logic [31:0]       bb;
  logic [31:0]       s_val;
  logic [31:0]       d_addr;
  logic [31:0]       step;
  logic [31:0]       res;
  logic [31:0]       target;
  logic [31:0]       sys_val;
  logic [32:0]       sum;
  logic [3:0]        res_flags;
  logic [5:0]        enter_num;
  logic [`CS_SYS_W-1:0] sys_sel;
  cs_region_s        f_region;
  cs_region_s        d_region;

  function automatic logic [31:0] read_reg(input logic [3:0]        idx,
                                           input logic [12:0][31:0] g,
                                           input logic [31:0]       sp,
                                           input logic [31:0]       lk,
                                           input logic [31:0]       pc);
    logic [31:0] v;
    case (idx)
      `CS_REG_SP:      v = sp; // RL8
      `CS_REG_LINK:    v = lk;
      `CS_REG_COUNTER: v = pc;
      default:         v = g[idx];
    endcase
    return v;
  endfunction : read_reg

  function automatic logic low_ok(input cs_op_s o);
    logic hi;
    hi = (o.rd > `CS_LOW_LAST) || (o.rn > `CS_LOW_LAST)
      || (!o.use_imm && (o.rm > `CS_LOW_LAST));
    case (o.kind)
      K_SUB, K_MUL, K_LDR, K_STR: low_ok = !hi; // RL12
      default:                    low_ok = 1'b1;
    endcase
  endfunction : low_ok

  // reset release through two stages
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_n_q1 <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_n_q1 <= 1'b1;
      rst_n    <= rst_n_q1;
    end
  end

  cs_addr_map u_fetch_map (
    .addr    (prog_cnt_reg),
    .region  (f_region),
    .mapped  (),
    .exec_ok (f_exec_ok)
  );

  cs_addr_map u_data_map (
    .addr    (d_addr),
    .region  (d_region),
    .mapped  (d_mapped),
    .exec_ok ()
  );

  assign handler     = (exc_num_reg != `CS_EXC_THREAD);
  assign use_proc_sp = spsel_reg && !handler; // RL7 RL18
  assign cur_sp      = use_proc_sp ? proc_sp_reg : main_sp_reg; // RL8
  assign a_val   = read_reg(s1_reg.rn, gpr_reg, cur_sp, link_reg, prog_cnt_reg);
  assign s_val   = read_reg(s1_reg.rd, gpr_reg, cur_sp, link_reg, prog_cnt_reg);
  assign b_val   = s1_reg.use_imm ? s1_reg.imm
                 : read_reg(s1_reg.rm, gpr_reg, cur_sp, link_reg, prog_cnt_reg);
  assign d_addr  = a_val + b_val;
  assign step    = s1_reg.wide ? `CS_STEP_WIDE : `CS_STEP_NARROW;
  assign sys_sel = s1_reg.imm[`CS_SYS_W-1:0];
  assign is_mem  = (s1_reg.kind == K_LDR) || (s1_reg.kind == K_STR);
  // second stage executes whatever the first stage holds
  assign exec_go = (state_reg == S_RUN) && s1_valid_reg; // RL15
  assign fault_now = exec_go && (!tbit_reg || !f_exec_ok || !low_ok(s1_reg)
                   || (is_mem && !d_mapped)); // RL20 RL3 RL21 RL12
  assign mem_fault = (state_reg == S_MEM) && req_reg && bus_ready && bus_err;
  assign ld_done   = (state_reg == S_MEM) && req_reg && bus_ready && !bus_err
                  && !write_reg;
  // no nesting: a handler runs to its return before the next request
  assign take_int  = (state_reg == S_RUN) && exc_req && !handler
                  && (!mask_reg || !exc_cfg); // RL9 RL19
  assign enter_exc = fault_now || mem_fault || take_int;
  assign enter_num = (fault_now || mem_fault) ? `CS_EXC_HARD_FAULT : exc_num;
  assign exec_ok   = exec_go && !enter_exc;
  assign redirect  = (exec_ok && branch)
                  || (wr_en && (wr_idx == `CS_REG_COUNTER)); // RL17

  always_comb begin
    case (sys_sel)
      `CS_SYS_FLAGS:     sys_val = 32'(flag_reg) << `CS_FLAG_LO; // RL11
      `CS_SYS_EXEC:      sys_val = 32'(tbit_reg) << `CS_TBIT_POS;
      `CS_SYS_EXCNUM:    sys_val = 32'(exc_num_reg); // RL10
      `CS_SYS_STATUS:    sys_val = (32'(flag_reg) << `CS_FLAG_LO)
                                 | (32'(tbit_reg) << `CS_TBIT_POS)
                                 | 32'(exc_num_reg);
      `CS_SYS_MAIN_SP:   sys_val = main_sp_reg;
      `CS_SYS_PROC_SP:   sys_val = proc_sp_reg;
      `CS_SYS_EXC_MASK:  sys_val = 32'(mask_reg) << `CS_MASK_BIT;
      `CS_SYS_STACK_SEL: sys_val = 32'(spsel_reg) << `CS_SPSEL_BIT;
      default:           sys_val = `CS_ZERO;
    endcase
  end

  always_comb begin
    bb        = (s1_reg.kind == K_SUB) ? ~b_val : b_val;
    sum       = {1'b0, a_val} + {1'b0, bb}
              + {`CS_ZERO, s1_reg.kind == K_SUB};
    res       = sum[31:0];
    res_flags = {res[31], res == `CS_ZERO, sum[32],
                 (a_val[31] == bb[31]) && (res[31] != a_val[31])};
    set_flags = 1'b0;
    wr_en     = 1'b0;
    branch    = 1'b0;
    target    = b_val;
    case (s1_reg.kind)
      K_MOV: begin
        res   = b_val;
        wr_en = 1'b1;
      end
      K_ADD, K_SUB: begin
        wr_en     = 1'b1;
        set_flags = 1'b1; // RL11
      end
      K_MUL: begin
        // full array multiplier: costs area, keeps the op single-cycle
        res       = a_val * b_val; // RL14
        res_flags = {res[31], res == `CS_ZERO, flag_reg[1:0]};
        wr_en     = 1'b1;
        set_flags = 1'b1;
      end
      K_B, K_BL: begin
        branch = 1'b1; // RL17
      end
      K_ERET: begin
        branch = 1'b1;
        target = a_val;
      end
      K_MRS: begin
        res   = sys_val;
        wr_en = 1'b1;
      end
      default: begin
        wr_en = 1'b0;
      end
    endcase
    wr_en   = wr_en && exec_ok;
    wr_idx  = s1_reg.rd;
    wr_data = res;
    if (ld_done) begin
      wr_en   = 1'b1;
      wr_idx  = ld_rd_reg;
      wr_data = bus_rdata;
    end
  end

  // sequencer and system bus master
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_BOOT;
      req_reg   <= 1'b0;
      write_reg <= 1'b0;
      addr_reg  <= `CS_ZERO;
      wdata_reg <= `CS_ZERO;
      ld_rd_reg <= `CS_REG_SP;
    end else begin
      case (state_reg)
        S_BOOT: begin
          req_reg   <= 1'b1;
          write_reg <= 1'b0;
          addr_reg  <= `CS_VEC_SP; // RL5
          state_reg <= S_RST_SP;
        end
        S_RST_SP: begin
          if (bus_ready) begin
            addr_reg  <= `CS_VEC_PC; // RL6
            state_reg <= S_RST_PC;
          end
        end
        S_RST_PC: begin
          if (bus_ready) begin
            req_reg   <= 1'b0;
            state_reg <= S_RUN;
          end
        end
        S_RUN: begin
          if (enter_exc) begin
            req_reg   <= 1'b1;
            write_reg <= 1'b0;
            addr_reg  <= `CS_VEC_TABLE
                       + (32'(enter_num) << `CS_VEC_SHIFT); // RL1
            state_reg <= S_VEC;
          end else if (exec_ok && is_mem) begin
            req_reg   <= 1'b1;
            write_reg <= (s1_reg.kind == K_STR);
            addr_reg  <= d_addr;
            wdata_reg <= s_val; // RL13
            ld_rd_reg <= s1_reg.rd;
            state_reg <= S_MEM;
          end
        end
        S_MEM: begin
          if (mem_fault) begin
            write_reg <= 1'b0;
            addr_reg  <= `CS_VEC_TABLE
                       + (32'(enter_num) << `CS_VEC_SHIFT);
            state_reg <= S_VEC;
          end else if (bus_ready) begin
            req_reg   <= 1'b0;
            state_reg <= S_RUN;
          end
        end
        S_VEC: begin
          if (bus_ready) begin
            req_reg   <= 1'b0;
            state_reg <= S_RUN;
          end
        end
        default: begin
          req_reg   <= 1'b0;
          state_reg <= S_BOOT;
        end
      endcase
    end
  end

  // register file, banked stack pointers, link register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpr_reg     <= '0;
      main_sp_reg <= `CS_ZERO;
      proc_sp_reg <= `CS_ZERO;
      link_reg    <= `CS_ZERO;
    end else begin
      if (state_reg == S_RST_SP && bus_ready) begin
        main_sp_reg <= bus_rdata & `CS_SP_MASK; // RL5
      end else if (exec_ok && s1_reg.kind == K_MSR
                   && sys_sel == `CS_SYS_MAIN_SP) begin
        main_sp_reg <= a_val & `CS_SP_MASK;
      end else if (wr_en && wr_idx == `CS_REG_SP && !use_proc_sp) begin
        main_sp_reg <= wr_data & `CS_SP_MASK; // RL8
      end
      if (exec_ok && s1_reg.kind == K_MSR && sys_sel == `CS_SYS_PROC_SP) begin
        proc_sp_reg <= a_val & `CS_SP_MASK;
      end else if (wr_en && wr_idx == `CS_REG_SP && use_proc_sp) begin
        proc_sp_reg <= wr_data & `CS_SP_MASK; // RL7
      end
      if (enter_exc) begin
        link_reg <= `CS_EXC_RETURN; // RL16
      end else if (exec_ok && s1_reg.kind == K_BL) begin
        link_reg <= (prog_cnt_reg + step) | `CS_LINK_STATE; // RL16
      end else if (wr_en && wr_idx == `CS_REG_LINK) begin
        link_reg <= wr_data;
      end
      if (wr_en && wr_idx < `CS_REG_SP) begin
        gpr_reg[wr_idx] <= wr_data; // RL13
      end
    end
  end

  // program counter and execution state bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_cnt_reg <= `CS_ZERO;
      tbit_reg     <= 1'b0;
    end else if ((state_reg == S_RST_PC || state_reg == S_VEC) && bus_ready) begin
      prog_cnt_reg <= bus_rdata & `CS_ADDR_MASK; // RL6
      tbit_reg     <= bus_rdata[0]; // RL6
    end else if (wr_en && wr_idx == `CS_REG_COUNTER) begin
      prog_cnt_reg <= wr_data & `CS_ADDR_MASK; // RL17
    end else if (exec_ok && branch) begin
      prog_cnt_reg <= target & `CS_ADDR_MASK; // RL17
    end else if (exec_ok) begin
      prog_cnt_reg <= prog_cnt_reg + step;
    end
  end

  // flags, exception mask, stack select, exception number
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg    <= '0;
      mask_reg    <= 1'b0;
      spsel_reg   <= 1'b0;
      exc_num_reg <= `CS_EXC_THREAD;
    end else begin
      if (exec_ok && set_flags) begin
        flag_reg <= res_flags; // RL11
      end else if (exec_ok && s1_reg.kind == K_MSR
                   && (sys_sel == `CS_SYS_FLAGS || sys_sel == `CS_SYS_STATUS)) begin
        flag_reg <= a_val[`CS_FLAG_HI:`CS_FLAG_LO]; // RL11
      end
      if (exec_ok && s1_reg.kind == K_CPS) begin
        mask_reg <= s1_reg.imm[`CS_MASK_BIT]; // RL9
      end else if (exec_ok && s1_reg.kind == K_MSR
                   && sys_sel == `CS_SYS_EXC_MASK) begin
        mask_reg <= a_val[`CS_MASK_BIT]; // RL9
      end
      if (exec_ok && s1_reg.kind == K_MSR && sys_sel == `CS_SYS_STACK_SEL
          && !handler) begin
        spsel_reg <= a_val[`CS_SPSEL_BIT]; // RL18
      end
      if (enter_exc) begin
        exc_num_reg <= enter_num; // RL10
      end else if (exec_ok && s1_reg.kind == K_ERET) begin
        exc_num_reg <= `CS_EXC_THREAD;
      end
    end
  end

  // first pipeline stage and handshake; redirects squash wrong-path ops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg       <= '0;
      s1_valid_reg <= 1'b0;
      ready_reg    <= 1'b0;
      flush_reg    <= 1'b0;
      ack_reg      <= 1'b0;
      fault_reg    <= 1'b0;
    end else begin
      if (enter_exc || redirect) begin
        s1_valid_reg <= 1'b0;
      end else if (op_valid && ready_reg) begin
        s1_reg       <= op; // RL15
        s1_valid_reg <= 1'b1;
      end else if (exec_ok) begin
        s1_valid_reg <= 1'b0;
      end
      ready_reg <= ((state_reg == S_RUN) && !enter_exc && !(exec_ok && is_mem))
                || (state_reg == S_RST_PC && bus_ready)
                || (state_reg == S_VEC && bus_ready)
                || (state_reg == S_MEM && bus_ready && !bus_err);
      flush_reg <= enter_exc || redirect;
      ack_reg   <= take_int && !fault_now;
      fault_reg <= fault_now || mem_fault; // RL20 RL21
    end
  end

  assign op_ready    = ready_reg;
  assign flush       = flush_reg;
  assign bus_req     = req_reg;
  assign bus_write   = write_reg;
  assign bus_addr    = addr_reg;
  assign bus_wdata   = wdata_reg;
  assign exc_ack     = ack_reg;
  assign hard_fault  = fault_reg;
  assign counter_out = prog_cnt_reg;
  assign status_out  = {flag_reg, tbit_reg, exc_num_reg};
  assign mask_out    = mask_reg;
  assign spsel_out   = spsel_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_reset_sp_addr: assert property (state_reg == S_RST_SP |-> bus_req && bus_addr == `CS_VEC_SP) else $error("reset stack fetch not at vector base"); // RL5
  a_reset_sp_load: assert property ((state_reg == S_RST_SP && bus_ready) |=> main_sp_reg == ($past(bus_rdata) & `CS_SP_MASK)) else $error("main stack not loaded at reset"); // RL5
  a_reset_pc_load: assert property ((state_reg == S_RST_PC && bus_ready) |=> prog_cnt_reg == ($past(bus_rdata) & `CS_ADDR_MASK) && tbit_reg == $past(bus_rdata[0])) else $error("counter or state bit wrong after reset"); // RL6
  a_handler_sel_hold: assert property ((exec_ok && s1_reg.kind == K_MSR && sys_sel == `CS_SYS_STACK_SEL && handler) |=> $stable(spsel_reg)) else $error("stack select changed in handler"); // RL18
  a_mask_blocks: assert property ((state_reg == S_RUN && exc_req && exc_cfg && mask_reg) |=> !ack_reg) else $error("masked exception taken"); // RL9
  a_unmaskable_taken: assert property ((state_reg == S_RUN && exc_req && !exc_cfg && !handler && !exec_go) |=> ack_reg && exc_num_reg == $past(exc_num) ##1 state_reg == S_VEC) else $error("unmaskable exception not taken"); // RL19
  a_tbit_fault: assert property ((exec_go && !tbit_reg) |=> fault_reg && exc_num_reg == `CS_EXC_HARD_FAULT) else $error("clear state bit did not fault"); // RL20
  a_periph_no_exec: assert property ((exec_go && f_region.periph) |=> fault_reg) else $error("executed from peripheral space"); // RL3
  a_unmapped_error: assert property ((exec_go && is_mem && !d_mapped) |=> fault_reg && state_reg == S_VEC) else $error("unmapped access not faulted"); // RL21
  a_high_reg_fault: assert property ((exec_go && s1_reg.kind == K_SUB && s1_reg.rd > `CS_LOW_LAST) |=> fault_reg) else $error("restricted op reached high register"); // RL12
  a_call_link: assert property ((exec_ok && s1_reg.kind == K_BL) |=> link_reg == (($past(prog_cnt_reg) + $past(step)) | `CS_LINK_STATE) && prog_cnt_reg == ($past(b_val) & `CS_ADDR_MASK)) else $error("call did not save link or jump"); // RL16
  a_mul_one_cycle: assert property ((exec_ok && s1_reg.kind == K_MUL && s1_reg.rd < `CS_REG_SP) |=> gpr_reg[$past(s1_reg.rd)] == $past(a_val) * $past(b_val)) else $error("multiply result late or wrong"); // RL14
  a_thread_proc_sp: assert property ((exec_ok && s1_reg.kind == K_MOV && s1_reg.rd == `CS_REG_SP && use_proc_sp) |=> proc_sp_reg == ($past(b_val) & `CS_SP_MASK) && $stable(main_sp_reg)) else $error("wrong stack pointer written"); // RL7

  c_boot_done: cover property (state_reg == S_RST_PC && bus_ready ##1 state_reg == S_RUN);
  c_exc_taken: cover property (ack_reg ##[1:4] state_reg == S_RUN);
  c_load_done: cover property (ld_done);
  c_hard_fault: cover property (fault_reg);

endmodule : cs_core_state

// ===== src/cs_defines.svh
`ifndef CS_DEFINES_SVH
`define CS_DEFINES_SVH

`define CS_VEC_TABLE      32'h00000000
`define CS_VEC_SP         32'h00000000
`define CS_VEC_PC         32'h00000004
`define CS_VEC_SHIFT      2
`define CS_CODE_LAST      32'h1FFFFFFF
`define CS_SRAM_BASE      32'h20000000
`define CS_SRAM_LAST      32'h3FFFFFFF
`define CS_PERI_BASE      32'h40000000
`define CS_PERI_LAST      32'h5FFFFFFF
`define CS_CORE_BASE      32'hE0000000
`define CS_CORE_LAST      32'hE00FFFFF
`define CS_DEV_BASE       32'hE0100000
`define CS_ADDR_MASK      32'hFFFFFFFE
`define CS_SP_MASK        32'hFFFFFFFC
`define CS_LINK_STATE     32'h00000001
`define CS_EXC_RETURN     32'hFFFFFFF9
`define CS_ZERO           32'h00000000
`define CS_STEP_WIDE      32'h00000004
`define CS_STEP_NARROW    32'h00000002
`define CS_EXC_THREAD     6'h00
`define CS_EXC_HARD_FAULT 6'h03
`define CS_REG_SP         4'hD
`define CS_REG_LINK       4'hE
`define CS_REG_COUNTER    4'hF
`define CS_LOW_LAST       4'h7
`define CS_SYS_W          5
`define CS_SYS_FLAGS      5'h00
`define CS_SYS_STATUS     5'h03
`define CS_SYS_EXCNUM     5'h05
`define CS_SYS_EXEC       5'h06
`define CS_SYS_MAIN_SP    5'h08
`define CS_SYS_PROC_SP    5'h09
`define CS_SYS_EXC_MASK   5'h10
`define CS_SYS_STACK_SEL  5'h14
`define CS_FLAG_LO        28
`define CS_FLAG_HI        31
`define CS_TBIT_POS       24
`define CS_SPSEL_BIT      1
`define CS_MASK_BIT       0

`endif

// ===== src/cs_pkg.sv
package cs_pkg;

  typedef enum logic [3:0] {
    K_NOP  = 4'h0,
    K_MOV  = 4'h1,
    K_ADD  = 4'h2,
    K_SUB  = 4'h3,
    K_MUL  = 4'h4,
    K_B    = 4'h5,
    K_BL   = 4'h6,
    K_MSR  = 4'h7,
    K_MRS  = 4'h8,
    K_LDR  = 4'h9,
    K_STR  = 4'hA,
    K_CPS  = 4'hB,
    K_ERET = 4'hC
  } cs_kind_e;

  typedef struct packed {
    cs_kind_e    kind;
    logic        wide;
    logic        use_imm;
    logic [3:0]  rd;
    logic [3:0]  rn;
    logic [3:0]  rm;
    logic [31:0] imm;
  } cs_op_s;

  typedef enum logic [5:0] {
    S_BOOT   = 6'h01,
    S_RST_SP = 6'h02,
    S_RST_PC = 6'h04,
    S_RUN    = 6'h08,
    S_MEM    = 6'h10,
    S_VEC    = 6'h20
  } cs_state_e;

  typedef struct packed {
    logic code;
    logic sram;
    logic periph;
    logic core;
    logic dev;
  } cs_region_s;

  typedef struct packed {
    logic [3:0] flags;
    logic       tbit;
    logic [5:0] exc_num;
  } cs_status_s;

endpackage : cs_pkg

// ===== src/cs_addr_map.sv
`timescale 1ns/1ps
`include "cs_defines.svh"

module cs_addr_map
  import cs_pkg::*;
(
  input  logic [31:0] addr,
  output cs_region_s  region,
  output logic        mapped,
  output logic        exec_ok
);

  always_comb begin
    region.code   = (addr <= `CS_CODE_LAST); // RL1
    region.sram   = (addr >= `CS_SRAM_BASE) && (addr <= `CS_SRAM_LAST); // RL2
    region.periph = (addr >= `CS_PERI_BASE) && (addr <= `CS_PERI_LAST); // RL3
    region.core   = (addr >= `CS_CORE_BASE) && (addr <= `CS_CORE_LAST); // RL4
    region.dev    = (addr >= `CS_DEV_BASE);
    // the hole between peripherals and core space answers nothing
    mapped  = region.code || region.sram || region.periph
           || region.core || region.dev; // RL21
    // only code and data memory may supply instructions
    exec_ok = region.code || region.sram; // RL2 RL3
  end

endmodule : cs_addr_map

// ===== test/cs_mem_model.sv
`timescale 1ns/1ps
module cs_mem_model (
  input  logic        ref_clk,
  input  logic        nrst,
  input  logic        slow,
  input  logic        bus_req,
  input  logic [31:0] bus_addr,
  output logic [31:0] bus_rdata,
  output logic        bus_ready,
  output logic        bus_err
);
  logic wait_reg;
  // vector table sits at address zero; other words are address-derived
  function automatic logic [31:0] cs_word(input logic [31:0] a);
    case (a)
      32'h00000000: return 32'h20000800;
      32'h00000004: return 32'h00000101;
      default:      return {a[15:0], 16'h0001};
    endcase
  endfunction : cs_word
  // slow mode inserts one wait cycle before answering
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bus_ready <= 1'b0;
      wait_reg  <= 1'b0;
      bus_rdata <= 32'h0;
    end else if (bus_req && !bus_ready && (wait_reg || !slow)) begin
      bus_ready <= 1'b1;
      wait_reg  <= 1'b0;
      bus_rdata <= cs_word(bus_addr);
    end else begin
      bus_ready <= 1'b0;
      wait_reg  <= bus_req && !bus_ready;
      bus_rdata <= ~bus_rdata; // stale data never looks valid
    end
  end
  assign bus_err = 1'b0;
endmodule : cs_mem_model

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cs_pkg::*;
  logic        ref_clk  = 1'b0;
  logic        nrst     = 1'b0;
  logic        op_valid = 1'b0;
  logic        exc_req  = 1'b0;
  logic        exc_cfg  = 1'b0;
  logic        slow     = 1'b0;
  logic [5:0]  exc_num  = 6'h00;
  cs_op_s      op       = '0;
  logic        op_ready, flush, bus_req, bus_write, bus_ready, bus_err;
  logic        exc_ack, hard_fault, mask_out, spsel_out, seen;
  logic [31:0] bus_addr, bus_wdata, bus_rdata, counter_out;
  cs_status_s  status_out;
  cs_op_s      row_op [7];
  logic [4:0]  row_exp [7];
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          i;

  cs_core_state dut (.*);
  cs_mem_model mem (.ref_clk(ref_clk), .nrst(nrst), .slow(slow),
    .bus_req(bus_req), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready), .bus_err(bus_err));

  always #20 ref_clk = ~ref_clk;

  task automatic final_report;
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  function automatic cs_op_s mk(cs_kind_e k, logic [3:0] rd, logic [31:0] v);
    return cs_op_s'{k, 1'b0, 1'b1, rd, 4'h0, 4'h0, v};
  endfunction : mk

  // op held until an edge with op_ready high takes it
  task automatic issue(input cs_op_s o);
    op = o;
    op_valid = 1'b1;
    while (!op_ready) @(posedge ref_clk) #1;
    @(posedge ref_clk) #1;
    op_valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : issue

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    row_op[0] = mk(K_MOV, 4'h0, 32'h5);
    row_exp[0] = 5'h00;
    row_op[1] = mk(K_SUB, 4'h1, 32'h5);
    row_exp[1] = 5'h06;
    row_op[2] = mk(K_SUB, 4'h1, 32'h6);
    row_exp[2] = 5'h08;
    row_op[3] = mk(K_ADD, 4'h2, 32'h7FFFFFFF);
    row_exp[3] = 5'h09;
    row_op[4] = mk(K_CPS, 4'h0, 32'h1);
    row_exp[4] = 5'h19;
    row_op[5] = mk(K_CPS, 4'h0, 32'h0);
    row_exp[5] = 5'h09;
    // multiply keeps carry and overflow from the add before it
    row_op[6] = mk(K_MUL, 4'h3, 32'h2);
    row_exp[6] = 5'h01;
    repeat (4) @(posedge ref_clk);
    #1;
    chk({op_ready, bus_req}, 2'h0);
    chk(counter_out, 32'h0);
    nrst = 1'b1;
    for (i = 0; i < 30 && !op_ready; i++) @(posedge ref_clk) #1;
    chk(counter_out, 32'h100);
    chk(status_out, 11'h040);
    chk({mask_out, spsel_out}, 2'h0);
    for (i = 0; i < 7; i++) begin
      issue(row_op[i]);
      chk({mask_out, status_out.flags}, row_exp[i]);
      chk(counter_out, 32'h100 + 2 * (i + 1));
    end
    slow = 1'b1;
    issue(mk(K_CPS, 4'h0, 32'h1));
    {exc_req, exc_cfg, exc_num, seen} = {2'b11, 6'h10, 1'b0};
    repeat (8) @(posedge ref_clk) #1 seen |= exc_ack;
    chk(seen, 1'b0);
    {exc_cfg, exc_num} = {1'b0, 6'h02};
    for (i = 0; i < 12 && !exc_ack; i++) @(posedge ref_clk) #1;
    chk(exc_ack, 1'b1);
    exc_req = 1'b0;
    for (i = 0; i < 20 && !op_ready; i++) @(posedge ref_clk) #1;
    chk({counter_out, status_out.exc_num}, {32'h80000, 6'h02});
    op = mk(K_B, 4'h0, 32'h40000001);
    op_valid = 1'b1;
    for (i = 0; i < 12 && !hard_fault; i++) @(posedge ref_clk) #1;
    op_valid = 1'b0;
    chk(hard_fault, 1'b1);
    for (i = 0; i < 20 && !op_ready; i++) @(posedge ref_clk) #1;
    chk({counter_out, status_out.exc_num}, {32'hC0000, 6'h03});
    final_report();
  end
endmodule : testbench
